// [rtl/pin_mux_pkg.sv]
package pin_mux_pkg;

  // ==========================================================
  // Pin counts and field positions
  localparam int PORT_D_PINS = 6;
  localparam int PORT_E_PINS = 2;
  localparam int SEL_CAN_TX_BIT = 4;
  localparam int SEL_CAN_RX_BIT = 5;
  localparam int CAN_TX_PIN = 0;
  localparam int CAN_RX_PIN = 1;
  localparam int SER_TX_PIN = 0;
  localparam int SER_RX_PIN = 1;

  // ==========================================================
  // Values after reset
  localparam logic [5:0] PORT_D_PER_RST = 6'h00;
  localparam logic [5:0] PORT_D_PU_RST = 6'h3f;
  localparam logic [1:0] PORT_E_PER_RST = 2'h3;
  localparam logic [1:0] PORT_E_PU_RST = 2'h3;
  localparam logic [5:0] DDR_D_RST = 6'h00;
  localparam logic [1:0] DDR_E_RST = 2'h0;

  // ==========================================================
  // Per-pin function after decode
  typedef enum logic [3:0]
  {
    FN_GPIO = 4'h1,
    FN_CHIP_SEL = 4'h2,
    FN_CAN_TX = 4'h4,
    FN_CAN_RX = 4'h8
  } pin_fn_t;

endpackage

// [rtl/port_d_e_pin_function_mux.sv]
`timescale 1ns/100ps
module port_d_e_pin_function_mux
  import pin_mux_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [5:0] port_d_periph_enable,
  input wire logic [5:0] periph_select_reg,
  input wire logic [5:0] port_d_pullup_enable,
  input wire logic [5:0] port_d_dir,
  input wire logic [5:0] port_d_gpio_out,
  input wire logic [1:0] port_e_periph_enable,
  input wire logic [1:0] port_e_pullup_enable,
  input wire logic [1:0] port_e_dir,
  input wire logic [1:0] port_e_gpio_out,
  input wire logic bus_idle_drive,
  input wire logic bus_active,
  input wire logic [5:0] chip_sel_n,
  input wire logic can_second_tx,
  input wire logic serial0_tx,
  input wire logic [5:0] port_d_pad_in,
  input wire logic [1:0] port_e_pad_in,
  output logic [5:0] port_d_pad_out,
  output logic [5:0] port_d_pad_oe,
  output logic [5:0] port_d_pad_pu,
  output logic [1:0] port_e_pad_out,
  output logic [1:0] port_e_pad_oe,
  output logic [1:0] port_e_pad_pu,
  output logic [5:0] port_d_gpio_in,
  output logic [1:0] port_e_gpio_in,
  output logic can_second_rx,
  output logic serial0_rx
);

  // ==========================================================
  // Pad input synchronisers
  logic [5:0] d_meta_r;
  logic [5:0] d_sync_r;
  logic [1:0] e_meta_r;
  logic [1:0] e_sync_r;

  // Two stages; only the second stage feeds logic
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      d_meta_r <= 6'h3f;
      d_sync_r <= 6'h3f;
      e_meta_r <= 2'h3;
      e_sync_r <= 2'h3;
    end
    else
    begin
      d_meta_r <= port_d_pad_in;
      d_sync_r <= d_meta_r;
      e_meta_r <= port_e_pad_in;
      e_sync_r <= e_meta_r;
    end
  end

  // ==========================================================
  // Function decode per port D pin
  pin_fn_t d_fn [PORT_D_PINS];
  logic [5:0] d_out_nxt;
  logic [5:0] d_oe_nxt;
  logic [5:0] d_pu_nxt;

  genvar gi;
  generate
    for (gi = 0; gi < PORT_D_PINS; gi++)
    begin : g_pin_d
      // Pins 0 and 1 may go to CAN; the others only to chip selects
      always_comb
      begin
        d_fn[gi] = FN_GPIO;
        if (port_d_periph_enable[gi])
        begin
          if (gi == CAN_TX_PIN && periph_select_reg[SEL_CAN_TX_BIT])
            d_fn[gi] = FN_CAN_TX;
          else if (gi == CAN_RX_PIN && periph_select_reg[SEL_CAN_RX_BIT])
            d_fn[gi] = FN_CAN_RX;
          else
            d_fn[gi] = FN_CHIP_SEL;
        end
      end

      // Only the chosen function reaches the pad
      always_comb
      begin
        d_out_nxt[gi] = 1'b1;
        d_oe_nxt[gi] = 1'b0;
        d_pu_nxt[gi] = port_d_pullup_enable[gi];
        case (d_fn[gi])
          FN_GPIO:
          begin
            d_out_nxt[gi] = port_d_gpio_out[gi];
            d_oe_nxt[gi] = port_d_dir[gi];
          end
          FN_CHIP_SEL:
          begin
            // Idle bus with drive clear floats the select
            d_out_nxt[gi] = chip_sel_n[gi];
            d_oe_nxt[gi] = bus_active | bus_idle_drive;
          end
          FN_CAN_TX:
          begin
            // Open drain: only a dominant low is driven
            d_out_nxt[gi] = 1'b0;
            d_oe_nxt[gi] = ~can_second_tx;
          end
          FN_CAN_RX:
          begin
            d_oe_nxt[gi] = 1'b0;
            d_pu_nxt[gi] = 1'b1;
          end
          default:
          begin
            d_oe_nxt[gi] = 1'b0;
          end
        endcase
      end
    end
  endgenerate

  // ==========================================================
  // Port E decode: peripheral by default, GPIO when cleared
  logic [1:0] e_out_nxt;
  logic [1:0] e_oe_nxt;

  always_comb
  begin
    e_out_nxt = port_e_gpio_out;
    e_oe_nxt = port_e_dir;
    if (port_e_periph_enable[SER_TX_PIN])
    begin
      e_out_nxt[SER_TX_PIN] = serial0_tx;
      e_oe_nxt[SER_TX_PIN] = 1'b1;
    end
    if (port_e_periph_enable[SER_RX_PIN])
    begin
      e_out_nxt[SER_RX_PIN] = 1'b1;
      e_oe_nxt[SER_RX_PIN] = 1'b0;
    end
  end

  // ==========================================================
  // Pad drive registers; reset floats all and pulls all up
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      port_d_pad_out <= 6'h3f;
      port_d_pad_oe <= DDR_D_RST;
      port_d_pad_pu <= PORT_D_PU_RST;
      port_e_pad_out <= 2'h3;
      port_e_pad_oe <= DDR_E_RST;
      port_e_pad_pu <= PORT_E_PU_RST;
    end
    else
    begin
      port_d_pad_out <= d_out_nxt;
      port_d_pad_oe <= d_oe_nxt;
      port_d_pad_pu <= d_pu_nxt;
      port_e_pad_out <= e_out_nxt;
      port_e_pad_oe <= e_oe_nxt;
      port_e_pad_pu <= port_e_pullup_enable;
    end
  end

  // ==========================================================
  // Input fan-out; GPIO readback samples the pad regardless, peripherals only when routed
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      port_d_gpio_in <= 6'h3f;
      port_e_gpio_in <= 2'h3;
      can_second_rx <= 1'b1;
      serial0_rx <= 1'b1;
    end
    else
    begin
      port_d_gpio_in <= d_sync_r;
      port_e_gpio_in <= e_sync_r;
      // Held recessive unless routed, so stray levels are ignored
      can_second_rx <= (d_fn[CAN_RX_PIN] == FN_CAN_RX) ?
                       d_sync_r[CAN_RX_PIN] : 1'b1;
      serial0_rx <= port_e_periph_enable[SER_RX_PIN] ?
                    e_sync_r[SER_RX_PIN] : 1'b1;
    end
  end

  // ==========================================================
  // Checks
  // Several antecedents also test the sampled reset: the edge that releases it
  // still sees the registers loading their reset values
  cs_idle_float_a: assert property (@(posedge sys_clk) disable iff (rst)
    (d_fn[2] == FN_CHIP_SEL && !bus_active && !bus_idle_drive)
    |=> !port_d_pad_oe[2])
    else $error("chip select driven on idle bus");

  cs_active_drive_a: assert property (@(posedge sys_clk)
    disable iff (rst)
    (d_fn[3] == FN_CHIP_SEL && bus_active)
    |=> port_d_pad_oe[3] && port_d_pad_out[3] == $past(chip_sel_n[3]))
    else $error("chip select not passed through");

  d0_can_sel_a: assert property (@(posedge sys_clk) disable iff (rst)
    (port_d_periph_enable[0] && periph_select_reg[4] && can_second_tx)
    |=> !port_d_pad_oe[0])
    else $error("recessive can transmit driven");

  can_rx_pull_a: assert property (@(posedge sys_clk) disable iff (rst)
    (port_d_periph_enable[1] && periph_select_reg[5])
    |=> port_d_pad_pu[1] && !port_d_pad_oe[1])
    else $error("can receive lost pull-up");

  d_pullup_a: assert property (@(posedge sys_clk) disable iff (rst)
    !rst && !port_d_periph_enable[4] |=>
    port_d_pad_pu[4] == $past(port_d_pullup_enable[4]))
    else $error("port d pull-up mismatch");

  gpio_dir_a: assert property (@(posedge sys_clk) disable iff (rst)
    !rst && !port_d_periph_enable[5] |=>
    port_d_pad_oe[5] == $past(port_d_dir[5]) &&
    port_d_pad_out[5] == $past(port_d_gpio_out[5]))
    else $error("gpio direction not honoured");

  reset_state_a: assert property (@(posedge sys_clk)
    rst |=> port_e_pad_oe == 2'h0 && port_e_pad_pu == 2'h3 &&
    port_d_pad_oe == 6'h00)
    else $error("reset pad state wrong");

  e_pullup_a: assert property (@(posedge sys_clk) disable iff (rst)
    !rst |=> port_e_pad_pu == $past(port_e_pullup_enable))
    else $error("port e pull-up mismatch");

  serial_rx_a: assert property (@(posedge sys_clk) disable iff (rst)
    port_e_periph_enable[1] |=> !port_e_pad_oe[1])
    else $error("serial receive pin driven");

  serial_tx_a: assert property (@(posedge sys_clk) disable iff (rst)
    port_e_periph_enable[0] |=>
    port_e_pad_oe[0] && port_e_pad_out[0] == $past(serial0_tx))
    else $error("serial transmit not driven");

  // Pins 2 to 5 have no CAN option, so an enable always means select
  generate
    for (gi = 2; gi < PORT_D_PINS; gi++)
    begin : g_cs_chk
      cs_route_a: assert property (@(posedge sys_clk) disable iff (rst)
        !rst && port_d_periph_enable[gi] && bus_active
        |=> port_d_pad_oe[gi] && port_d_pad_out[gi] == $past(chip_sel_n[gi]))
        else $error("upper chip select not routed");
    end
  endgenerate

  // A dominant bit must pull the pad low, never drive it high
  can_tx_dominant_a: assert property (@(posedge sys_clk)
    disable iff (rst)
    !rst && port_d_periph_enable[0] && periph_select_reg[4] && !can_second_tx
    |=> port_d_pad_oe[0] && !port_d_pad_out[0])
    else $error("dominant can transmit not driven low");

  // Routed CAN receive carries the synchronised pad level
  can_rx_route_a: assert property (@(posedge sys_clk) disable iff (rst)
    !rst && port_d_periph_enable[1] && periph_select_reg[5]
    |=> can_second_rx == $past(d_sync_r[1]))
    else $error("can receive not routed");

  // Unrouted CAN receive rests recessive whatever the pad shows
  can_rx_idle_a: assert property (@(posedge sys_clk) disable iff (rst)
    !rst && !port_d_periph_enable[1] |=> can_second_rx)
    else $error("can receive not idle");

  // Pads reach the readback three edges later: two sync stages, one output
  sync_path_a: assert property (@(posedge sys_clk) disable iff (rst)
    (!rst)[*3] |=> {port_d_gpio_in, port_e_gpio_in} ==
    $past({port_d_pad_in, port_e_pad_in}, 3))
    else $error("pad level not passed to readback");

  cs_cover_c: cover property (@(posedge sys_clk)
    d_fn[2] == FN_CHIP_SEL && bus_active);
  can_tx_c: cover property (@(posedge sys_clk) d_fn[0] == FN_CAN_TX);
  can_rx_c: cover property (@(posedge sys_clk) d_fn[1] == FN_CAN_RX);
  e_gpio_c: cover property (@(posedge sys_clk)
    !port_e_periph_enable[0] && port_e_dir[0]);
  cs_float_c: cover property (@(posedge sys_clk)
    d_fn[2] == FN_CHIP_SEL && !bus_active && !bus_idle_drive);

endmodule

// [test/pad_far_side.sv]
`timescale 1ns/100ps
// ==========================================================
// Far side of the pads: outside drivers, pull-ups and floating
module pad_far_side
#(
  parameter int N = 6
)
(
  input wire logic clk,
  input wire logic [N-1:0] dev_out,
  input wire logic [N-1:0] dev_oe,
  input wire logic [N-1:0] dev_pu,
  input wire logic [N-1:0] ext_en,
  input wire logic [N-1:0] ext_val,
  output logic [N-1:0] pad
);
  logic [N-1:0] float_r = {N{1'b0}};

  // A floating pad toggles so a stale level never passes for data
  always_ff @(posedge clk)
    float_r <= ~float_r;

  // Device first, then outside drivers, then the pull-up
  always_comb
    for (int i = 0; i < N; i++)
      pad[i] = dev_oe[i] ? dev_out[i] : ext_en[i] ? ext_val[i] :
               dev_pu[i] ? 1'b1 : float_r[i];
endmodule

// [test/port_d_e_pin_function_mux_bench.sv]
`timescale 1ns/100ps
`define CHK(nm, ex, got) \
  begin \
    check_count++; \
    if ((got) !== (ex)) \
    begin \
      fail_count++; \
      $display("[ERR] %s expected %h seen %h", nm, ex, got); \
    end \
  end
module port_d_e_pin_function_mux_bench;
  import pin_mux_pkg::*;
  // ==========================================================
  // Stimulus and wiring
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [63:0] stim = 64'h0;
  logic [5:0] d_en, sel, d_pu, d_dir, d_out, cs_n, d_xv, d_pin;
  logic [1:0] e_en, e_pu, e_dir, e_out, e_xv, e_pin;
  logic drv_raw, drv, act, ctx, stx, crx, srx;
  logic [5:0] d_po, d_oe, d_pp, d_gi;
  logic [1:0] e_po, e_oe, e_pp, e_gi;
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  logic [63:0] corner [4] = '{64'h003f, 64'h0000_c000_00fc_0000,
                              64'h0c03, 64'h0020_0000_0000_003f};

  assign {stx, ctx, act, drv_raw, e_xv, e_out, e_dir, e_pu, e_en, d_xv,
          cs_n, d_out, d_dir, d_pu, sel, d_en} = stim[55:0];
  // Software mostly leaves the idle drive set
  assign drv = drv_raw | stim[56];

  always #25 sys_clk = ~sys_clk;

  port_d_e_pin_function_mux port_d_e_pin_function_mux_i (
    .sys_clk(sys_clk), .rst(rst), .port_d_periph_enable(d_en),
    .periph_select_reg(sel), .port_d_pullup_enable(d_pu),
    .port_d_dir(d_dir), .port_d_gpio_out(d_out),
    .port_e_periph_enable(e_en), .port_e_pullup_enable(e_pu),
    .port_e_dir(e_dir), .port_e_gpio_out(e_out),
    .bus_idle_drive(drv), .bus_active(act), .chip_sel_n(cs_n),
    .can_second_tx(ctx), .serial0_tx(stx), .port_d_pad_in(d_pin),
    .port_e_pad_in(e_pin), .port_d_pad_out(d_po), .port_d_pad_oe(d_oe),
    .port_d_pad_pu(d_pp), .port_e_pad_out(e_po), .port_e_pad_oe(e_oe),
    .port_e_pad_pu(e_pp), .port_d_gpio_in(d_gi), .port_e_gpio_in(e_gi),
    .can_second_rx(crx), .serial0_rx(srx));

  // Outside drivers back off whenever the pin drives
  pad_far_side #(.N(6)) pad_far_side_d_i (.clk(sys_clk), .dev_out(d_po),
    .dev_oe(d_oe), .dev_pu(d_pp), .ext_en(~d_oe), .ext_val(d_xv),
    .pad(d_pin));
  pad_far_side #(.N(2)) pad_far_side_e_i (.clk(sys_clk), .dev_out(e_po),
    .dev_oe(e_oe), .dev_pu(e_pp), .ext_en(~e_oe), .ext_val(e_xv),
    .pad(e_pin));

  // ==========================================================
  // Expected pin state: {pu checked, pu, oe, out}
  function automatic logic [3:0] exp_d(int n);
    if (!d_en[n])
      return {1'b1, d_pu[n], d_dir[n], d_out[n]};
    if (n == CAN_TX_PIN && sel[SEL_CAN_TX_BIT])
      return {1'b0, 1'b0, ~ctx, 1'b0};
    if (n == CAN_RX_PIN && sel[SEL_CAN_RX_BIT])
      return {1'b1, 1'b1, 1'b0, 1'b0};
    return {1'b1, d_pu[n], act | drv, cs_n[n]};
  endfunction

  // Port E: {pu, oe, out}
  function automatic logic [2:0] exp_e(int n);
    if (!e_en[n])
      return {e_pu[n], e_dir[n], e_out[n]};
    return {e_pu[n], n == SER_TX_PIN, stx};
  endfunction

  task automatic check_all();
    logic [3:0] x;
    logic [2:0] y;
    for (int n = 0; n < PORT_D_PINS; n++)
    begin
      x = exp_d(n);
      `CHK("d_oe", x[1], d_oe[n])
      if (x[1]) `CHK("d_out", x[0], d_po[n])
      if (x[3]) `CHK("d_pu", x[2], d_pp[n])
      `CHK("d_in", x[1] ? x[0] : d_xv[n], d_gi[n])
    end
    for (int n = 0; n < PORT_E_PINS; n++)
    begin
      y = exp_e(n);
      `CHK("e_oe", y[1], e_oe[n])
      if (y[1]) `CHK("e_out", y[0], e_po[n])
      `CHK("e_pu", y[2], e_pp[n])
      `CHK("e_in", y[1] ? y[0] : e_xv[n], e_gi[n])
    end
    `CHK("can_rx", (d_en[1] & sel[5]) ? d_xv[1] : 1'b1, crx)
    `CHK("ser_rx", e_en[1] ? e_xv[1] : 1'b1, srx)
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ==========================================================
  // Cut a hang short; the run needs about 1800 cycles
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      fail_count++;
      end_of_test();
    end
  end

  // Main sequence: reset, corner cases, then random configurations
  initial
  begin
    void'($urandom(55));
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    `CHK("rst_oe", 8'h00, {d_oe, e_oe})
    `CHK("rst_pu", 8'hff, {d_pp, e_pp})
    `CHK("rst_rx", 2'h3, {crx, srx})
    for (int k = 0; k < 300; k++)
    begin
      @(posedge sys_clk);
      stim <= (k < 4) ? corner[k] : {$urandom, $urandom};
      repeat (5) @(posedge sys_clk);
      @(negedge sys_clk);
      check_all();
    end
    end_of_test();
  end
endmodule
